// ---- cpuag_pkg.sv ----
// constants and types shared by the address generation block
// assumes a 20-bit address space and a 16-bit stack pointer
package cpuag_pkg;

	localparam int ADDR_W = 20;
	localparam int OFS_W = 16;
	localparam int BANK_W = 4;

	// fixed upper nibbles and region bases
	localparam logic [3:0] TOP_BANK = 4'hF;
	localparam logic [3:0] LOW_BANK = 4'h0;
	localparam logic [19:0] SHORT_LO_BASE = 20'hFFE00;
	localparam logic [19:0] SHORT_HI_BASE = 20'hFFF00;
	localparam logic [7:0] SHORT_WRAP = 8'h20;
	localparam logic [19:0] SPECIAL_BASE = 20'hFFF00;
	localparam logic [15:0] TABLE_BASE = 16'h0080;

	// general register indices
	localparam logic [2:0] REG_X = 3'h0;
	localparam logic [2:0] REG_C = 3'h2;
	localparam logic [2:0] REG_B = 3'h3;
	localparam logic [1:0] PAIR_AX = 2'h0;
	localparam logic [1:0] PAIR_DE = 2'h2;
	localparam logic [1:0] PAIR_HL = 2'h3;

	// stack bytes moved by each stack operation
	localparam logic [2:0] STK_BYTES_SHORT = 3'h2;
	localparam logic [2:0] STK_BYTES_LONG = 3'h4;

	typedef enum logic [3:0] {
		AM_REL = 4'h0,
		AM_IMM20 = 4'h1,
		AM_IMM16 = 4'h2,
		AM_TABLE = 4'h3,
		AM_REGIND_BR = 4'h4,
		AM_IMPLIED = 4'h5,
		AM_REG8 = 4'h6,
		AM_REG16 = 4'h7,
		AM_DIRECT = 4'h8,
		AM_SHORT = 4'h9,
		AM_SPECIAL = 4'hA,
		AM_REGIND = 4'hB,
		AM_BASED = 4'hC,
		AM_BASED_IDX = 4'hD,
		AM_STACK = 4'hE
	} cpuag_mode_t;

	typedef enum logic [1:0] {
		BASE_PAIR = 2'h0,
		BASE_SP = 2'h1,
		BASE_IMM = 2'h2
	} cpuag_base_t;

	typedef enum logic [1:0] {
		OFF_IMM8 = 2'h0,
		OFF_IMM16 = 2'h1,
		OFF_REG8 = 2'h2,
		OFF_PAIR = 2'h3
	} cpuag_off_t;

	typedef enum logic [2:0] {
		STK_PUSH = 3'h0,
		STK_POP = 3'h1,
		STK_CALL = 3'h2,
		STK_RET = 3'h3,
		STK_INT = 3'h4,
		STK_IRET = 3'h5
	} cpuag_stk_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_TBL_LO = 2'h1,
		ST_TBL_HI = 2'h2,
		ST_STACK = 2'h3
	} cpuag_state_t;

endpackage

// ---- cpuag_reg_pick.sv ----
// picks one 8-bit general register and one 16-bit pair from the bank
// assumes the bank is packed X,A,C,B,E,D,L,H from bit 0 upward
module cpuag_reg_pick
	import cpuag_pkg::*;
(
	// register bank
	input wire logic [63:0] reg_file,
	// selectors
	input wire logic [2:0] byte_sel,
	input wire logic [1:0] pair_sel,
	// picked values
	output logic [7:0] byte_val,
	output logic [15:0] pair_val
);

	always_comb
	begin
		byte_val = reg_file[{byte_sel, 3'h0} +: 8];
		pair_val = reg_file[{pair_sel, 4'h0} +: 16];
	end

endmodule

// ---- cpuag_bank_ext.sv ----
// widens a 16-bit data offset to a 20-bit operand address
// assumes the offset sum was already wrapped to 16 bits
module cpuag_bank_ext
	import cpuag_pkg::*;
(
	// offset and bank source
	input wire logic [15:0] offset,
	input wire logic bank_prefix,
	input wire logic [3:0] data_bank_register,
	// widened address
	output logic [19:0] addr
);

	always_comb
	begin
		if (bank_prefix)
			addr = {data_bank_register, offset};
		else
			addr = {TOP_BANK, offset};
	end

endmodule

// ---- cpuag_core.sv ----
// address generation for the core: branch targets and operand addresses
// assumes request fields are stable while req_valid is high and the core
// holds off new requests while busy is high
module cpuag_core
	import cpuag_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// request
	input wire logic req_valid,
	input wire logic [3:0] req_mode,
	input wire logic [19:0] imm,
	input wire logic [15:0] disp,
	input wire logic disp_long,
	input wire logic [2:0] reg_sel,
	input wire logic [1:0] pair_sel,
	input wire logic [1:0] base_kind,
	input wire logic [1:0] off_kind,
	input wire logic bank_prefix,
	input wire logic word_op,
	input wire logic is_call,
	input wire logic [2:0] stack_op,
	// core state
	input wire logic [63:0] reg_file,
	input wire logic [15:0] stack_ptr,
	input wire logic [3:0] code_bank,
	input wire logic [3:0] data_bank_register,
	input wire logic [19:0] next_pc,
	// table read port
	input wire logic tbl_rd_valid,
	input wire logic [7:0] tbl_rd_data,
	output logic tbl_rd_req,
	output logic [19:0] tbl_rd_addr,
	// program address
	output logic pc_load,
	output logic [19:0] pc_target,
	// operand address
	output logic opnd_valid,
	output logic opnd_is_reg,
	output logic opnd_word,
	output logic [2:0] opnd_reg_idx,
	output logic [19:0] opnd_addr,
	output logic addr_fault,
	// stack access
	output logic stk_valid,
	output logic stk_write,
	output logic [19:0] stk_addr,
	output logic sp_update,
	output logic [15:0] sp_next,
	// status
	output logic busy
);

	////////////////////////////////////////////////////////////////////////
	// register picks and offset arithmetic

	cpuag_state_t state;
	cpuag_mode_t mode;
	cpuag_base_t base_k;
	cpuag_off_t off_k;
	cpuag_stk_t stk_k;
	logic take;
	logic [7:0] sel_byte;
	logic [15:0] sel_pair;
	logic [7:0] idx_byte;
	logic [15:0] hl_pair;
	logic [15:0] base_val;
	logic [15:0] off_val;
	logic [15:0] data_ofs;
	logic [19:0] data_addr;
	logic [19:0] rel_ext;
	logic [7:0] fld;
	logic [2:0] stk_len;
	logic stk_is_push;
	logic bad;
	logic [7:0] tbl_lo;
	logic [15:0] tbl_entry;
	logic [15:0] stk_base;
	logic [2:0] stk_cnt;
	logic [2:0] stk_total;
	logic stk_dir_push;

	assign mode = cpuag_mode_t'(req_mode);
	assign base_k = cpuag_base_t'(base_kind);
	assign off_k = cpuag_off_t'(off_kind);
	assign stk_k = cpuag_stk_t'(stack_op);
	assign take = req_valid && (state == ST_IDLE);
	assign fld = imm[7:0];

	cpuag_reg_pick u_pick_sel (
		.reg_file(reg_file),
		.byte_sel(reg_sel),
		.pair_sel(pair_sel),
		.byte_val(sel_byte),
		.pair_val(sel_pair)
	);

	// second pick serves the HL base of the indexed form
	cpuag_reg_pick u_pick_hl (
		.reg_file(reg_file),
		.byte_sel(reg_sel),
		.pair_sel(PAIR_HL),
		.byte_val(idx_byte),
		.pair_val(hl_pair)
	);

	// base and offset of the based form
	always_comb
	begin
		case (base_k)
			BASE_PAIR: base_val = sel_pair;
			BASE_SP: base_val = stack_ptr;
			BASE_IMM: base_val = imm[15:0];
			default: base_val = imm[15:0];
		endcase
		case (off_k)
			OFF_IMM8: off_val = {8'h00, disp[7:0]};
			OFF_IMM16: off_val = disp;
			OFF_REG8: off_val = {8'h00, sel_byte};
			OFF_PAIR: off_val = sel_pair;
			default: off_val = disp;
		endcase
	end

	// sums wrap inside the low 16 bits
	always_comb
	begin
		case (mode)
			AM_DIRECT: data_ofs = imm[15:0];
			AM_REGIND: data_ofs = sel_pair;
			AM_BASED: data_ofs = 16'(base_val + off_val);
			AM_BASED_IDX: data_ofs = 16'(hl_pair + {8'h00, idx_byte});
			default: data_ofs = imm[15:0];
		endcase
	end

	cpuag_bank_ext u_bank_ext (
		.offset(data_ofs),
		.bank_prefix(bank_prefix),
		.data_bank_register(data_bank_register),
		.addr(data_addr)
	);

	// sign extension of the branch displacement
	always_comb
	begin
		if (disp_long)
			rel_ext = {{4{disp[15]}}, disp};
		else
			rel_ext = {{12{disp[7]}}, disp[7:0]};
	end

	// illegal combinations of the request fields
	always_comb
	begin
		bad = 1'b0;
		case (mode)
			AM_REGIND_BR: bad = !is_call && (pair_sel != PAIR_AX);
			AM_SHORT: bad = word_op && fld[0];
			AM_SPECIAL: bad = word_op && fld[0];
			AM_REGIND: bad = (pair_sel != PAIR_DE) && (pair_sel != PAIR_HL);
			AM_BASED: bad = bank_prefix && (base_k == BASE_SP);
			AM_BASED_IDX: bad = (reg_sel != REG_B) && (reg_sel != REG_C);
			default: bad = 1'b0;
		endcase
	end

	// stack byte counts per operation
	always_comb
	begin
		case (stk_k)
			STK_PUSH: stk_len = STK_BYTES_SHORT;
			STK_POP: stk_len = STK_BYTES_SHORT;
			default: stk_len = STK_BYTES_LONG;
		endcase
		stk_is_push = (stk_k == STK_PUSH) || (stk_k == STK_CALL) ||
			(stk_k == STK_INT);
	end

	assign tbl_entry = 16'(TABLE_BASE + {10'h000, imm[4:0], 1'b0});

	////////////////////////////////////////////////////////////////////////
	// sequencing

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			state <= ST_IDLE;
		else
		begin
			case (state)
				ST_IDLE:
				begin
					if (take && mode == AM_TABLE)
						state <= ST_TBL_LO;
					else if (take && mode == AM_STACK)
						state <= ST_STACK;
				end
				ST_TBL_LO:
				begin
					if (tbl_rd_valid)
						state <= ST_TBL_HI;
				end
				ST_TBL_HI:
				begin
					if (tbl_rd_valid)
						state <= ST_IDLE;
				end
				ST_STACK:
				begin
					if (stk_cnt == 3'(stk_total - 3'h1))
						state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			busy <= 1'b0;
		else
			busy <= (state == ST_IDLE) ? (take && (mode == AM_TABLE ||
				mode == AM_STACK)) : !((state == ST_TBL_HI && tbl_rd_valid) ||
				(state == ST_STACK && stk_cnt == 3'(stk_total - 3'h1)));
	end

	////////////////////////////////////////////////////////////////////////
	// program address

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pc_load <= 1'b0;
			pc_target <= 20'h00000;
		end
		else
		begin
			pc_load <= 1'b0;
			if (take)
			begin
				case (mode)
					AM_REL:
					begin
						pc_load <= 1'b1;
						pc_target <= 20'(next_pc + rel_ext);
					end
					AM_IMM20:
					begin
						pc_load <= 1'b1;
						pc_target <= imm;
					end
					AM_IMM16:
					begin
						pc_load <= 1'b1;
						pc_target <= {LOW_BANK, imm[15:0]};
					end
					AM_REGIND_BR:
					begin
						pc_load <= !bad;
						pc_target <= {code_bank, sel_pair};
					end
					default: pc_load <= 1'b0;
				endcase
			end
			else if (state == ST_TBL_HI && tbl_rd_valid)
			begin
				pc_load <= 1'b1;
				pc_target <= {LOW_BANK, tbl_rd_data, tbl_lo};
			end
		end
	end

	// table word fetch, low byte first
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tbl_rd_req <= 1'b0;
			tbl_rd_addr <= 20'h00000;
			tbl_lo <= 8'h00;
		end
		else
		begin
			tbl_rd_req <= 1'b0;
			if (take && mode == AM_TABLE)
			begin
				tbl_rd_req <= 1'b1;
				tbl_rd_addr <= {LOW_BANK, tbl_entry};
			end
			else if (state == ST_TBL_LO && tbl_rd_valid)
			begin
				tbl_lo <= tbl_rd_data;
				tbl_rd_req <= 1'b1;
				tbl_rd_addr <= {LOW_BANK, tbl_entry[15:1], 1'b1};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// operand address

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			opnd_valid <= 1'b0;
			opnd_is_reg <= 1'b0;
			opnd_word <= 1'b0;
			opnd_reg_idx <= 3'h0;
			opnd_addr <= 20'h00000;
		end
		else
		begin
			opnd_valid <= 1'b0;
			if (take)
			begin
				opnd_word <= word_op;
				opnd_is_reg <= 1'b0;
				case (mode)
					AM_IMPLIED:
					begin
						opnd_valid <= 1'b1;
						opnd_is_reg <= 1'b1;
						opnd_reg_idx <= REG_X;
					end
					AM_REG8:
					begin
						opnd_valid <= 1'b1;
						opnd_is_reg <= 1'b1;
						opnd_word <= 1'b0;
						opnd_reg_idx <= reg_sel;
					end
					AM_REG16:
					begin
						opnd_valid <= 1'b1;
						opnd_is_reg <= 1'b1;
						opnd_word <= 1'b1;
						opnd_reg_idx <= {pair_sel, 1'b0};
					end
					AM_SHORT:
					begin
						opnd_valid <= !bad;
						if (fld >= SHORT_WRAP)
							opnd_addr <= SHORT_LO_BASE | {12'h000, fld};
						else
							opnd_addr <= SHORT_HI_BASE | {12'h000, fld};
					end
					AM_SPECIAL:
					begin
						opnd_valid <= !bad;
						opnd_addr <= SPECIAL_BASE | {12'h000, fld};
					end
					AM_DIRECT, AM_REGIND, AM_BASED, AM_BASED_IDX:
					begin
						opnd_valid <= !bad;
						opnd_addr <= data_addr;
					end
					default: opnd_valid <= 1'b0;
				endcase
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			addr_fault <= 1'b0;
		else
			addr_fault <= take && bad;
	end

	////////////////////////////////////////////////////////////////////////
	// stack walk, one byte address per cycle

	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stk_base <= 16'h0000;
			stk_cnt <= 3'h0;
			stk_total <= 3'h1;
			stk_dir_push <= 1'b0;
		end
		else if (take && mode == AM_STACK)
		begin
			stk_base <= stack_ptr;
			stk_cnt <= 3'h0;
			stk_total <= stk_len;
			stk_dir_push <= stk_is_push;
		end
		else if (state == ST_STACK)
			stk_cnt <= 3'(stk_cnt + 3'h1);
	end

	// stack region is the top bank where internal RAM sits
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stk_valid <= 1'b0;
			stk_write <= 1'b0;
			stk_addr <= 20'h00000;
			sp_update <= 1'b0;
			sp_next <= 16'h0000;
		end
		else
		begin
			stk_valid <= state == ST_STACK;
			stk_write <= (state == ST_STACK) && stk_dir_push;
			sp_update <= 1'b0;
			if (state == ST_STACK)
			begin
				if (stk_dir_push)
					stk_addr <= {TOP_BANK,
						16'(stk_base - 16'h0001 - {13'h0000, stk_cnt})};
				else
					stk_addr <= {TOP_BANK,
						16'(stk_base + {13'h0000, stk_cnt})};
				if (stk_cnt == 3'(stk_total - 3'h1))
				begin
					sp_update <= 1'b1;
					if (stk_dir_push)
						sp_next <= 16'(stk_base - {13'h0000, stk_total});
					else
						sp_next <= 16'(stk_base + {13'h0000, stk_total});
				end
			end
		end
	end

endmodule

// ---- cpuag_core_chk.sv ----
// concurrent checks on the ports of the address generation core
// assumes one clock domain, ref_clk, and the active-low reset rst_b
module cpuag_core_chk
	import cpuag_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// request and core state
	input wire logic req_valid,
	input wire logic [3:0] req_mode,
	input wire logic [19:0] imm,
	input wire logic [15:0] disp,
	input wire logic disp_long,
	input wire logic bank_prefix,
	input wire logic word_op,
	input wire logic [2:0] stack_op,
	input wire logic [15:0] stack_ptr,
	input wire logic [3:0] data_bank_register,
	input wire logic [19:0] next_pc,
	// answers
	input wire logic tbl_rd_req,
	input wire logic [19:0] tbl_rd_addr,
	input wire logic pc_load,
	input wire logic [19:0] pc_target,
	input wire logic opnd_valid,
	input wire logic [19:0] opnd_addr,
	input wire logic addr_fault,
	input wire logic stk_valid,
	input wire logic [19:0] stk_addr,
	input wire logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic take;
	logic odd_word;
	logic [19:0] rel_exp;
	logic [19:0] dir_exp;
	logic [19:0] sh_exp;
	logic [19:0] tbl_exp;
	assign take = req_valid && !busy;
	assign odd_word = word_op && imm[0];
	assign rel_exp = next_pc + (disp_long ? {{4{disp[15]}}, disp}
		: {{12{disp[7]}}, disp[7:0]});
	assign dir_exp = {bank_prefix ? data_bank_register : 4'hF, imm[15:0]};
	assign sh_exp = {(imm[7:0] >= 8'h20) ? 12'hFFE : 12'hFFF, imm[7:0]};
	assign tbl_exp = {12'h000, 2'b10, imm[4:0], 1'b0};
	////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// two push bytes, top of stack downward
	sequence push_bytes;
		##2 stk_valid && stk_addr == {4'hF, $past(stack_ptr, 2) - 16'h0001}
		##1 stk_valid && stk_addr == {4'hF, $past(stack_ptr, 3) - 16'h0002};
	endsequence
	rel_branch_a:
	assert property (take && req_mode == AM_REL |=>
		pc_load && pc_target == $past(rel_exp))
		else $error("relative branch target wrong");
	imm16_target_a:
	assert property (take && req_mode == AM_IMM16 |=>
		pc_load && pc_target == ($past(imm) & 20'h0FFFF))
		else $error("16-bit branch target wrong");
	table_entry_a:
	assert property (take && req_mode == AM_TABLE |=>
		tbl_rd_req && busy && tbl_rd_addr == $past(tbl_exp))
		else $error("table entry address wrong");
	table_low_a:
	assert property ($past(busy) && pc_load |-> pc_target[19:16] == 4'h0)
		else $error("table target outside low 64 KB");
	short_region_a:
	assert property (take && req_mode == AM_SHORT && !odd_word |=>
		opnd_valid && opnd_addr == $past(sh_exp))
		else $error("short direct address wrong");
	odd_word_a:
	assert property (take && (req_mode == AM_SHORT ||
		req_mode == AM_SPECIAL) && odd_word |=> addr_fault && !opnd_valid)
		else $error("odd word operand not refused");
	direct_bank_a:
	assert property (take && req_mode == AM_DIRECT |=>
		opnd_valid && opnd_addr == $past(dir_exp))
		else $error("direct address wrong");
	push_stack_a:
	assert property (take && req_mode == AM_STACK && stack_op == STK_PUSH
		|-> push_bytes)
		else $error("push stack bytes wrong");
endmodule
////////////////////////////////////////////////////////////
bind cpuag_core cpuag_core_chk u_chk (.ref_clk, .rst_b, .req_valid,
	.req_mode, .imm, .disp, .disp_long, .bank_prefix, .word_op, .stack_op,
	.stack_ptr, .data_bank_register, .next_pc, .tbl_rd_req, .tbl_rd_addr,
	.pc_load, .pc_target, .opnd_valid, .opnd_addr, .addr_fault, .stk_valid,
	.stk_addr, .busy);

// ---- tb_cpuag_core.sv ----
// self-checking bench for the address generation core
// assumes the package, design and checker are compiled before it
module tb_cpuag_core
	import cpuag_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, tbl_rd_valid = 1'b0;
	logic disp_long = 1'b0, bank_prefix = 1'b0, word_op = 1'b0, is_call = 1'b0;
	logic [3:0] req_mode = 4'h0, code_bank = 4'h5, data_bank_register = 4'h3;
	logic [19:0] imm = 20'h0, next_pc = 20'hFFFF0;
	logic [15:0] disp = 16'h0, stack_ptr = 16'hFE00;
	logic [2:0] reg_sel = 3'h0, stack_op = 3'h0;
	logic [1:0] pair_sel = 2'h0, base_kind = 2'h0, off_kind = 2'h0;
	logic [7:0] tbl_rd_data = 8'h00;
	logic [63:0] reg_file = 64'hFFF0_1122_3344_0506;
	logic tbl_rd_req, pc_load, opnd_valid, opnd_is_reg, opnd_word, addr_fault;
	logic stk_valid, stk_write, sp_update, busy;
	logic [2:0] opnd_reg_idx;
	logic [19:0] tbl_rd_addr, pc_target, opnd_addr, stk_addr;
	logic [15:0] sp_next;
	int err_total = 0, n_tests = 0;
	always #4 ref_clk = ~ref_clk;
	cpuag_core u_dut (.ref_clk, .rst_b, .req_valid, .req_mode, .imm, .disp,
		.disp_long, .reg_sel, .pair_sel, .base_kind, .off_kind, .bank_prefix,
		.word_op, .is_call, .stack_op, .reg_file, .stack_ptr, .code_bank,
		.data_bank_register, .next_pc, .tbl_rd_valid, .tbl_rd_data,
		.tbl_rd_req, .tbl_rd_addr, .pc_load, .pc_target, .opnd_valid,
		.opnd_is_reg, .opnd_word, .opnd_reg_idx, .opnd_addr, .addr_fault,
		.stk_valid, .stk_write, .stk_addr, .sp_update, .sp_next, .busy);
	////////////////////////////////////////////////////////////
	task automatic ck(input logic [19:0] g, input logic [19:0] e);
		n_tests++;
		if (g !== e)
		begin
			$display("wrong value at %0t: got %h want %h", $time, g, e);
			err_total++;
		end
	endtask
	// one request after an idle cycle; returns while the answer pulses stand
	task automatic ask(input logic [3:0] m, input logic [19:0] a,
		input logic [15:0] d);
		@(negedge ref_clk);
		req_mode = m;
		imm = a;
		disp = d;
		req_valid = 1'b1;
		@(negedge ref_clk);
		req_valid = 1'b0;
	endtask
	task automatic stop_test();
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_branch();
		ask(AM_REL, 20'h0, 16'h0080);
		ck(pc_load, 1'b1);
		ck(pc_target, 20'hFFF70);
		disp_long = 1'b1;
		ask(AM_REL, 20'h0, 16'h7FFF);
		ck(pc_target, 20'h07FEF);
		disp_long = 1'b0;
		ask(AM_IMM20, 20'hABCDE, 16'h0);
		ck(pc_target, 20'hABCDE);
		ask(AM_IMM16, 20'hABCDE, 16'h0);
		ck(pc_target, 20'h0BCDE);
		ask(AM_REGIND_BR, 20'h0, 16'h0);
		ck(pc_target, 20'h50506);
		pair_sel = PAIR_HL;
		is_call = 1'b1;
		ask(AM_REGIND_BR, 20'h0, 16'h0);
		ck(pc_target, 20'h5FFF0);
		is_call = 1'b0;
		ask(AM_REGIND_BR, 20'h0, 16'h0);
		ck(addr_fault, 1'b1);
		ck(pc_load, 1'b0);
	endtask
	// table call with a request slipped in while busy
	task automatic t_table();
		ask(AM_TABLE, 20'h0001F, 16'h0);
		ck(tbl_rd_req, 1'b1);
		ck(tbl_rd_addr, 20'h000BE);
		ck(busy, 1'b1);
		@(negedge ref_clk);
		tbl_rd_data = 8'h34;
		tbl_rd_valid = 1'b1;
		req_mode = AM_REL;
		req_valid = 1'b1;
		@(negedge ref_clk);
		tbl_rd_valid = 1'b0;
		req_valid = 1'b0;
		ck(pc_load, 1'b0);
		ck(tbl_rd_req, 1'b1);
		ck(tbl_rd_addr, 20'h000BF);
		@(negedge ref_clk);
		tbl_rd_data = 8'h12;
		tbl_rd_valid = 1'b1;
		@(negedge ref_clk);
		tbl_rd_valid = 1'b0;
		ck(pc_load, 1'b1);
		ck(pc_target, 20'h01234);
		ck(busy, 1'b0);
	endtask
	task automatic t_operand();
		ask(AM_IMPLIED, 20'h0, 16'h0);
		ck(opnd_reg_idx, REG_X);
		ck(opnd_valid, 1'b1);
		ck(opnd_is_reg, 1'b1);
		reg_sel = 3'h5;
		ask(AM_REG8, 20'h0, 16'h0);
		ck(opnd_reg_idx, 3'h5);
		ask(AM_REG16, 20'h0, 16'h0);
		ck(opnd_reg_idx, 3'h6);
		ck(opnd_word, 1'b1);
		ask(AM_SHORT, 20'hFFE20, 16'h0);
		ck(opnd_addr, 20'hFFE20);
		ck(opnd_valid, 1'b1);
		ck(opnd_is_reg, 1'b0);
		ask(AM_SHORT, 20'h0001F, 16'h0);
		ck(opnd_addr, 20'hFFF1F);
		word_op = 1'b1;
		ask(AM_SHORT, 20'h00021, 16'h0);
		ck(addr_fault, 1'b1);
		ck(opnd_valid, 1'b0);
		ask(AM_SPECIAL, 20'h000FE, 16'h0);
		ck(opnd_addr, 20'hFFFFE);
		ask(AM_SPECIAL, 20'h00001, 16'h0);
		ck(addr_fault, 1'b1);
		word_op = 1'b0;
	endtask
	task automatic t_data();
		ask(AM_DIRECT, 20'h01234, 16'h0);
		ck(opnd_addr, 20'hF1234);
		pair_sel = PAIR_DE;
		ask(AM_REGIND, 20'h0, 16'h0);
		ck(opnd_addr, 20'hF1122);
		pair_sel = 2'h1;
		ask(AM_REGIND, 20'h0, 16'h0);
		ck(addr_fault, 1'b1);
		pair_sel = PAIR_HL;
		ask(AM_BASED, 20'h0, 16'h12FF);
		ck(opnd_addr, 20'hF00EF);
		base_kind = BASE_SP;
		ask(AM_BASED, 20'h0, 16'h0010);
		ck(opnd_addr, 20'hFFE10);
		base_kind = BASE_IMM;
		off_kind = OFF_REG8;
		reg_sel = REG_B;
		ask(AM_BASED, 20'h01000, 16'h0);
		ck(opnd_addr, 20'hF1033);
		reg_sel = REG_C;
		ask(AM_BASED_IDX, 20'h0, 16'h0);
		ck(opnd_addr, 20'hF0034);
		bank_prefix = 1'b1;
		ask(AM_DIRECT, 20'h01234, 16'h0);
		ck(opnd_addr, 20'h31234);
		ask(AM_BASED_IDX, 20'h0, 16'h0);
		ck(opnd_addr, 20'h30034);
		bank_prefix = 1'b0;
	endtask
	// every stack operation: byte count, direction and new pointer
	task automatic t_stack();
		int n;
		logic wr;
		for (int op = 0; op < 6; op++)
		begin
			n = (op < 2) ? 2 : 4;
			wr = (op == STK_PUSH || op == STK_CALL || op == STK_INT);
			stack_op = 3'(op);
			ask(AM_STACK, 20'h0, 16'h0);
			ck(busy, 1'b1);
			for (int i = 0; i < n; i++)
			begin
				@(negedge ref_clk);
				ck(stk_valid, 1'b1);
				ck(stk_write, wr);
				ck(stk_addr, {4'hF, wr ? stack_ptr - 16'(i + 1)
					: stack_ptr + 16'(i)});
			end
			ck(sp_update, 1'b1);
			ck(sp_next, wr ? stack_ptr - 16'(n) : stack_ptr + 16'(n));
			@(negedge ref_clk);
			ck(stk_valid, 1'b0);
			ck(busy, 1'b0);
		end
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(negedge ref_clk);
		rst_b = 1'b1;
		@(negedge ref_clk);
		t_branch();
		t_table();
		t_operand();
		t_data();
		t_stack();
		stop_test();
	end
	initial
	begin
		#20000;
		err_total++;
		stop_test();
	end
endmodule
